// ### src/gcb_cond_eval.sv
`timescale 1ns/1ns
// Branch condition evaluation from opcode and flags
module gcb_cond_eval
  import gcb_pkg::*;
(
  // Opcode
  input  wire logic [7:0] opcode,
  // Flags
  input  wire logic       carryFlag,
  input  wire logic       zeroFlag,
  input  wire logic       signFlag,
  input  wire logic       ovfFlag,
  // Result
  output logic            isBranch,
  output logic            takeBranch
);
  // Decode and evaluate
  always_comb begin
    isBranch   = 1'b1;
    takeBranch = 1'b0;
    unique case (opcode)
      OP_BRANCH_CARRY_CLEAR: takeBranch = !carryFlag;
      OP_BRANCH_CARRY_SET:   takeBranch = carryFlag;
      OP_BRANCH_ON_ZERO:     takeBranch = zeroFlag;
      OP_BRANCH_SIGNED_GE:   takeBranch = !(signFlag ^ ovfFlag);
      OP_BRANCH_SIGNED_LT:   takeBranch = signFlag ^ ovfFlag;
      default:               isBranch   = 1'b0;
    endcase
  end
endmodule // gcb_cond_eval

// ### src/gcb_core.sv
`timescale 1ns/1ns
// Branch and bit-clear executor for one instruction byte stream
module gcb_core
  import gcb_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Instruction byte stream
  input  wire logic [7:0]  fetchByte,
  input  wire logic        fetchValid,
  input  wire logic        fromCache,
  output logic             fetchReady,
  // Flags in
  input  wire logic        carryFlag,
  input  wire logic        zeroIn,
  input  wire logic        signIn,
  input  wire logic        ovfFlag,
  // Register file read
  output logic [3:0]       srcSel,
  output logic [3:0]       opSel,
  input  wire logic [15:0] srcData,
  input  wire logic [15:0] opData,
  // Results
  output logic [15:0]      progCounter,
  output logic [15:0]      statusOut,
  output logic [15:0]      wrData,
  output logic [3:0]       wrSel,
  output logic             wrEn,
  output logic             delaySlot,
  output logic             branchTaken
);
  typedef struct packed {
    gcb_state_t  st;
    logic [15:0] pc;
    logic [3:0]  cnt;
    logic        taken;
    logic        alternate_prefix_one;
    logic        alternate_prefix_two;
    logic [3:0]  src;
    logic [3:0]  dst;
    logic        sign;
    logic        zero;
    logic [15:0] wdat;
    logic [3:0]  wsel;
    logic        wen;
    logic        slot;
    logic        brk;
  } gcb_core_t;

  gcb_core_t s_r;
  gcb_core_t s_nxt;
  logic      isBranch;
  logic      takeNow;
  logic [15:0] clearRes;
  logic [15:0] opMask;
  logic [15:0] offsetExt;

  gcb_cond_eval i_gcb_cond_eval (
    .opcode     (fetchByte),
    .carryFlag  (carryFlag),
    .zeroFlag   (zeroIn),
    .signFlag   (signIn),
    .ovfFlag    (ovfFlag),
    .isBranch   (isBranch),
    .takeBranch (takeNow)
  );

  // Operand fields and bit-clear result
  assign srcSel    = s_r.src;
  assign opSel     = fetchByte[3:0];
  assign opMask    = s_r.alternate_prefix_two ? {12'h000, fetchByte[3:0]} : opData;
  assign clearRes  = srcData & ~opMask;
  assign offsetExt = {{8{fetchByte[7]}}, fetchByte};
  assign fetchReady = (s_r.st != ST_WAIT);

  // Outputs from state
  assign progCounter = s_r.pc;
  assign wrData      = s_r.wdat;
  assign wrSel       = s_r.wsel;
  assign wrEn        = s_r.wen;
  assign delaySlot   = s_r.slot;
  assign branchTaken = s_r.brk;

  // Status word assembled at the named bit positions
  always_comb begin
    statusOut           = WORD_ZERO;
    statusOut[ALTERNATE_PREFIX_ONE_BIT] = s_r.alternate_prefix_one;
    statusOut[ALTERNATE_PREFIX_TWO_BIT] = s_r.alternate_prefix_two;
    statusOut[SIGN_BIT] = s_r.sign;
  end

  // Next state
  always_comb begin
    s_nxt      = s_r;
    s_nxt.wen  = 1'b0;
    s_nxt.slot = 1'b0;
    s_nxt.brk  = 1'b0;
    unique case (s_r.st)
      ST_FETCH: begin
        if (fetchValid) begin
          s_nxt.pc = s_r.pc + PC_STEP;
          if (s_r.taken) begin
            s_nxt.slot  = 1'b1;
            s_nxt.taken = 1'b0;
          end
          if (fetchByte == OP_ALT_PREFIX_ONE) begin
            s_nxt.alternate_prefix_one = 1'b1;
          end else if (fetchByte == OP_ALT_PREFIX_TWO) begin
            s_nxt.alternate_prefix_two = 1'b1;
          end else if (fetchByte == OP_ALT_PREFIX_BOTH) begin
            s_nxt.alternate_prefix_one = 1'b1;
            s_nxt.alternate_prefix_two = 1'b1;
          end else if (fetchByte[7:4] == OP_HI_SELECT_DEST) begin
            s_nxt.dst = fetchByte[3:0];
          end else if (fetchByte[7:4] == OP_HI_SELECT_SRC) begin
            s_nxt.src = fetchByte[3:0];
          end else if (fetchByte[7:4] == OP_HI_SELECT_BOTH) begin
            s_nxt.src = fetchByte[3:0];
            s_nxt.dst = fetchByte[3:0];
          end else if (isBranch && !s_r.alternate_prefix_one && !s_r.alternate_prefix_two) begin
            s_nxt.taken = takeNow;
            s_nxt.st    = ST_OFFSET;
          end else if (fetchByte[7:4] == OP_HI_BITCLEAR && s_r.alternate_prefix_one) begin
            s_nxt.wdat = clearRes;
            s_nxt.wsel = s_r.dst;
            s_nxt.wen  = 1'b1;
            s_nxt.sign = clearRes[SIGN_BIT];
            s_nxt.zero = (clearRes == WORD_ZERO);
            s_nxt.alternate_prefix_one = 1'b0;
            s_nxt.alternate_prefix_two = 1'b0;
            s_nxt.src  = REG_DEFAULT;
            s_nxt.dst  = REG_DEFAULT;
            // Prefix and operand bytes both count toward the total
            s_nxt.cnt  = (fromCache ? CYC_FAST : CYC_SLOW) - CYC_ONE - CYC_ONE;
            s_nxt.st   = (s_nxt.cnt == 4'h0) ? ST_FETCH : ST_WAIT;
          end
        end
      end
      ST_OFFSET: begin
        if (fetchValid) begin
          s_nxt.pc = s_r.pc + PC_STEP;
          if (s_r.taken) begin
            s_nxt.pc  = s_r.pc + PC_STEP + offsetExt;
            s_nxt.brk = 1'b1;
          end
          s_nxt.cnt = (fromCache ? CYC_FAST : CYC_SLOW) - CYC_ONE - CYC_ONE;
          s_nxt.st  = (s_nxt.cnt == 4'h0) ? ST_FETCH : ST_WAIT;
        end
      end
      ST_WAIT: begin
        s_nxt.cnt = s_r.cnt - CYC_ONE;
        if (s_r.cnt <= CYC_ONE) begin
          s_nxt.st = ST_FETCH;
        end
      end
      default: s_nxt.st = ST_FETCH;                             // Unused state code
    endcase
  end

  // State register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '{st: ST_FETCH, pc: WORD_ZERO, cnt: 4'h0, taken: 1'b0, alternate_prefix_one: 1'b0, alternate_prefix_two: 1'b0,
               src: REG_DEFAULT, dst: REG_DEFAULT, sign: 1'b0, zero: 1'b0, wdat: WORD_ZERO,
               wsel: REG_DEFAULT, wen: 1'b0, slot: 1'b0, brk: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Accepted byte with no prefix pending
  logic plainFetch;
  assign plainFetch = (s_r.st == ST_FETCH) && fetchValid && !s_r.alternate_prefix_one && !s_r.alternate_prefix_two;

  // Taken branch lands on the address after the offset byte plus offset
  sequence takenOffset_s;
    s_r.st == ST_OFFSET && fetchValid && s_r.taken;
  endsequence
  branch_target_a: assert property (@(posedge core_clk) disable iff (!nrst)
    takenOffset_s |=> s_r.pc == $past(s_r.pc) + PC_STEP + $past(offsetExt))
    else $error("branch target wrong");
  // Offset byte leaves the status word alone
  branch_flags_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (s_r.st == ST_OFFSET && fetchValid) |=> $stable(statusOut))
    else $error("branch changed status");
  // Carry clear branch decision
  carry_clear_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (plainFetch && fetchByte == OP_BRANCH_CARRY_CLEAR) |=> s_r.taken == !$past(carryFlag))
    else $error("carry clear decision wrong");
  // Carry set decision
  carry_set_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (plainFetch && fetchByte == OP_BRANCH_CARRY_SET) |=> s_r.taken == $past(carryFlag))
    else $error("carry set decision wrong");
  // Zero branch decision
  zero_branch_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (plainFetch && fetchByte == OP_BRANCH_ON_ZERO) |=> s_r.taken == $past(zeroIn))
    else $error("zero decision wrong");
  // Signed compare decisions
  signed_ge_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (plainFetch && fetchByte == OP_BRANCH_SIGNED_GE) |=> s_r.taken == !($past(signIn) ^ $past(ovfFlag)))
    else $error("signed ge decision wrong");
  signed_lt_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (plainFetch && fetchByte == OP_BRANCH_SIGNED_LT) |=> s_r.taken == ($past(signIn) ^ $past(ovfFlag)))
    else $error("signed lt decision wrong");
  // Cache branch takes two cycles
  sequence cacheBranch_s;
    plainFetch && isBranch && fromCache;
  endsequence
  cache_timing_a: assert property (@(posedge core_clk) disable iff (!nrst)
    cacheBranch_s ##1 fetchValid |=> s_r.st == ST_FETCH)
    else $error("cache branch timing wrong");
  // Slow bit-clear holds fetch off for four cycles
  sequence clearByte_s;
    s_r.st == ST_FETCH && fetchValid && s_r.alternate_prefix_one && fetchByte[7:4] == OP_HI_BITCLEAR;
  endsequence
  slow_clear_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (clearByte_s and !fromCache) |=> !fetchReady [*4] ##1 fetchReady)
    else $error("slow bit-clear timing wrong");
  // Cache bit-clear takes the next byte at once
  fast_clear_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (clearByte_s and fromCache) |=> fetchReady)
    else $error("cache bit-clear timing wrong");
  // Bit-clear result and zero flag
  clear_result_a: assert property (@(posedge core_clk) disable iff (!nrst)
    clearByte_s |=> wrEn && wrData == $past(clearRes) && wrSel == $past(s_r.dst) && !s_r.alternate_prefix_one
          && s_r.zero == (wrData == WORD_ZERO))
    else $error("bit-clear result wrong");
  // Applied branch keeps the delay byte pending
  taken_pending_a: assert property (@(posedge core_clk) disable iff (!nrst)
    branchTaken |-> s_r.taken)
    else $error("delay byte not pending");
  // Next accepted byte after a taken branch is marked
  sequence delayByte_s;
    s_r.st == ST_FETCH && fetchValid && s_r.taken;
  endsequence
  delay_slot_a: assert property (@(posedge core_clk) disable iff (!nrst)
    delayByte_s |=> delaySlot)
    else $error("delay slot not marked");
endmodule // gcb_core

// ### src/gcb_pkg.sv
package gcb_pkg;
  localparam logic [7:0] OP_BRANCH_CARRY_CLEAR = 8'h0C;
  localparam logic [7:0] OP_BRANCH_CARRY_SET   = 8'h0D;
  localparam logic [7:0] OP_BRANCH_ON_ZERO     = 8'h09;
  localparam logic [7:0] OP_BRANCH_SIGNED_GE   = 8'h07;
  localparam logic [7:0] OP_BRANCH_SIGNED_LT   = 8'h06;
  localparam logic [7:0] OP_ALT_PREFIX_ONE     = 8'h3D;
  localparam logic [7:0] OP_ALT_PREFIX_TWO     = 8'h3E;
  localparam logic [7:0] OP_ALT_PREFIX_BOTH    = 8'h3F;
  localparam logic [3:0] OP_HI_BITCLEAR        = 4'h7;
  localparam logic [3:0] OP_HI_SELECT_DEST     = 4'h1;
  localparam logic [3:0] OP_HI_SELECT_SRC      = 4'hB;
  localparam logic [3:0] OP_HI_SELECT_BOTH     = 4'h2;
  localparam int         ALTERNATE_PREFIX_ONE_BIT              = 8;
  localparam int         ALTERNATE_PREFIX_TWO_BIT              = 9;
  localparam int         SIGN_BIT              = 15;
  localparam logic [3:0] REG_DEFAULT           = 4'h0;
  localparam logic [3:0] REG_PC                = 4'hF;
  localparam logic [3:0] CYC_SLOW              = 4'h6;
  localparam logic [3:0] CYC_FAST              = 4'h2;
  localparam logic [3:0] CYC_ONE               = 4'h1;
  localparam logic [15:0] PC_STEP              = 16'h0001;
  localparam logic [15:0] WORD_ZERO            = 16'h0000;
  typedef enum logic [1:0] {ST_FETCH, ST_OFFSET, ST_WAIT} gcb_state_t;
endpackage

// ### verification/gcb_fetch_model.sv
`timescale 1ns/1ns
// Program store that streams up to four bytes in order
module gcb_fetch_model (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Program load
  input  wire logic        go,
  input  wire logic [31:0] progWord,
  input  wire logic [2:0]  progLen,
  // Byte stream
  input  wire logic        fetchReady,
  output logic [7:0]       fetchByte,
  output logic             fetchValid
);
  logic [2:0] ptr;
  logic [7:0] lastByte;

  // Advance only on an accepted byte; opcode always ahead of its operand
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ptr      <= 3'h7;
      lastByte <= 8'h00;
    end else if (go) begin
      ptr <= 3'h0;
    end else if (fetchValid && fetchReady) begin
      ptr      <= ptr + 3'h1;
      lastByte <= fetchByte;
    end
  end

  // Outside the program the line shows the inverse of the last byte
  // No byte is offered while a new program is being loaded
  assign fetchValid = !go && (ptr < progLen);
  assign fetchByte  = fetchValid ? progWord[31 - 8 * ptr -: 8] : ~lastByte;
endmodule // gcb_fetch_model

// ### verification/tb_gcb_core.sv
`timescale 1ns/1ns
// Bench for the branch and bit-clear executor
module tb_gcb_core;
  import gcb_pkg::*;
  logic        core_clk, nrst, go, fromCache, fetchValid, fetchReady, wrEn, delaySlot, branchTaken;
  logic        carryFlag, zeroIn, signIn, ovfFlag, sawTake, sawDelay, sawWr, sawAlt, t;
  logic [7:0]  fetchByte;
  logic [31:0] progWord;
  logic [2:0]  progLen;
  logic [3:0]  srcSel, opSel, wrSel, gotSel;
  logic [15:0] srcData, opData, progCounter, statusOut, wrData, gotData, takePc, expPc, oldStat;
  int          num_errors, compares, cycles, lowCnt;
  // Opcode, offset, carry/zero/sign/overflow
  logic [19:0] tbl [10] = '{20'h0C05_0, 20'h0C7F_8, 20'h0D80_8, 20'h0DFD_0, 20'h0903_4,
                            20'h0903_0, 20'h07FD_3, 20'h07FD_2, 20'h0604_2, 20'h0604_0};

  // Register file contents seen by the core
  function automatic logic [15:0] rf(input logic [3:0] k);
    return 16'hC5CE ^ {k, k, k, k};
  endfunction
  assign srcData = rf(srcSel);
  assign opData  = rf(opSel);

  gcb_core i_gcb_core (.core_clk(core_clk), .nrst(nrst), .fetchByte(fetchByte), .fetchValid(fetchValid),
    .fromCache(fromCache), .fetchReady(fetchReady), .carryFlag(carryFlag), .zeroIn(zeroIn), .signIn(signIn),
    .ovfFlag(ovfFlag), .srcSel(srcSel), .opSel(opSel), .srcData(srcData), .opData(opData),
    .progCounter(progCounter), .statusOut(statusOut), .wrData(wrData), .wrSel(wrSel), .wrEn(wrEn),
    .delaySlot(delaySlot), .branchTaken(branchTaken));
  gcb_fetch_model i_gcb_fetch_model (.core_clk(core_clk), .nrst(nrst), .go(go), .progWord(progWord),
    .progLen(progLen), .fetchReady(fetchReady), .fetchByte(fetchByte), .fetchValid(fetchValid));

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Monitor of pulses, wait cycles and the hang limit
  always @(posedge core_clk) begin
    cycles++;
    if (!fetchReady) lowCnt++;
    if (branchTaken) begin sawTake = 1'b1; takePc = progCounter; end
    if (delaySlot) sawDelay = 1'b1;
    if (wrEn) begin sawWr = 1'b1; gotSel = wrSel; gotData = wrData; end
    if (statusOut[ALTERNATE_PREFIX_ONE_BIT]) sawAlt = 1'b1;
    if (cycles == 2000) begin num_errors++; wrap_up(); end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  function automatic logic takes(input logic [7:0] op, input logic [3:0] f);
    case (op)
      OP_BRANCH_CARRY_CLEAR: return !f[3];
      OP_BRANCH_CARRY_SET:   return f[3];
      OP_BRANCH_ON_ZERO:     return f[2];
      OP_BRANCH_SIGNED_GE:   return !(f[1] ^ f[0]);
      default:               return f[1] ^ f[0];
    endcase
  endfunction

  // Load a program, start the stream and let it finish
  task automatic run(input logic [31:0] w, input logic [2:0] n, input logic c);
    @(negedge core_clk);
    progWord = w; progLen = n; fromCache = c; go = 1'b1; oldStat = statusOut;
    lowCnt = 0; sawTake = 1'b0; sawDelay = 1'b0; sawWr = 1'b0; sawAlt = 1'b0;
    @(negedge core_clk);
    go = 1'b0;
    repeat (14) @(negedge core_clk);
  endtask

  task automatic bitclr(input logic [31:0] w, input logic [2:0] n, input logic c, input logic [3:0] d,
                        input logic [15:0] v, input int low);
    run(w, n, c);
    expPc = expPc + 16'(n);
    chk("bic pc", progCounter, expPc);
    chk("bic write", sawWr, 1'b1);
    chk("bic dest", gotSel, d);
    chk("bic data", gotData, v);
    chk("bic sign", statusOut[SIGN_BIT], v[15]);
    chk("bic prefix", statusOut[ALTERNATE_PREFIX_ONE_BIT], 1'b0);
    chk("alt seen", sawAlt, 1'b1);
    if (low >= 0) chk("bic waits", lowCnt, low);
  endtask

  task automatic wrap_up();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Main sequence
  initial begin
    nrst = 1'b0; go = 1'b0; progWord = 32'h0; progLen = 3'h0; fromCache = 1'b0; expPc = 16'h0;
    {carryFlag, zeroIn, signIn, ovfFlag} = 4'h0;
    num_errors = 0; compares = 0; cycles = 0; lowCnt = 0;
    repeat (8) @(negedge core_clk);
    nrst = 1'b1;
    chk("pc reset", progCounter, 16'h0000);
    // Every branch kind, taken and not, ROM and cache alternately
    for (int i = 0; i < 10; i++) begin
      {carryFlag, zeroIn, signIn, ovfFlag} = tbl[i][3:0];
      t = takes(tbl[i][19:12], tbl[i][3:0]);
      expPc = expPc + 16'h0002 + (t ? {{8{tbl[i][11]}}, tbl[i][11:4]} : 16'h0000);
      run({tbl[i][19:4], 16'h0000}, 3'h2, i[0]);
      chk("pc", progCounter, expPc);
      chk("taken", sawTake, t);
      chk("status", statusOut, oldStat);
      chk("waits", lowCnt, i[0] ? 0 : 4);
    end
    // Bit-clear: default registers, selected registers, immediate
    bitclr(32'h3D71_0000, 3'h2, 1'b0, 4'h0, rf(0) & ~rf(1), 4);
    bitclr(32'h3D73_0000, 3'h2, 1'b1, 4'h0, rf(0) & ~rf(3), 0);
    bitclr(32'hB215_3D7F, 3'h4, 1'b1, 4'h5, rf(2) & ~rf(15), 0);
    bitclr(32'h3F7A_0000, 3'h2, 1'b0, 4'h0, rf(0) & ~16'h000A, 4);
    // Taken branch whose delay byte is a prefix
    carryFlag = 1'b0;
    run(32'h0C05_3D71, 3'h4, 1'b0);
    chk("delay target", takePc, expPc + 16'h0007);
    chk("delay slot", sawDelay, 1'b1);
    chk("delay exec", sawWr, 1'b1);
    wrap_up();
  end
endmodule // tb_gcb_core
